// ==== isl_pkg.sv ====
// Notes on behaviour
// - Store accumulator through pointer with update mode
// - Indexed store of accumulator at pointer plus offset
// - Flow change or true test costs two cycles
// - Indirect or indexed access whose effective address has its top bit set adds one cycle
// - Pointer add of signed six-bit literal, flags kept
// - Pointer arithmetic wraps modulo 65536
// - AND immediate into accumulator, zero flag only
// - Add immediate into accumulator, carry, digit carry, zero
// - AND accumulator with file, destination bit chooses target
`default_nettype none
package isl_pkg;
    localparam logic [13:0] STORE_IND_MASK = 14'h3FF8;
    localparam logic [13:0] STORE_IND_MATCH = 14'h0018;
    localparam logic [13:0] STORE_IDX_MASK = 14'h3F80;
    localparam logic [13:0] STORE_IDX_MATCH = 14'h3F80;
    localparam logic [13:0] PTR_ADD_MASK = 14'h3F80;
    localparam logic [13:0] PTR_ADD_MATCH = 14'h3100;
    localparam logic [13:0] LIT_MASK = 14'h3F00;
    localparam logic [13:0] AND_LIT_MATCH = 14'h3900;
    localparam logic [13:0] ADD_LIT_MATCH = 14'h3E00;
    localparam logic [13:0] AND_FILE_MATCH = 14'h0500;
    localparam logic [1:0] MODE_PRE_INC = 2'h0;
    localparam logic [1:0] MODE_PRE_DEC = 2'h1;
    localparam logic [1:0] MODE_POST_INC = 2'h2;
    localparam logic [1:0] MODE_POST_DEC = 2'h3;
    localparam logic [6:0] IND_PORT0_ADDR = 7'h00;
    localparam logic [6:0] IND_PORT1_ADDR = 7'h01;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ACC = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_PTR0 = 8'h0C;
    localparam logic [7:0] ADDR_PTR1 = 8'h10;
    localparam logic [7:0] ADDR_CYCLES = 8'h14;
    localparam int CTRL_RUN_BIT = 0;
    localparam int ST_C_BIT = 0;
    localparam int ST_DC_BIT = 1;
    localparam int ST_Z_BIT = 2;
    localparam logic CTRL_RESET = 1'b0;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [1:0] FLOW_EXTRA_CYCLES = 2'h1;
    localparam logic [1:0] IND_EXTRA_CYCLES = 2'h1;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] data;
    } isl_mem_wr_t;
endpackage
`default_nettype wire

// ==== isl_core.sv ====
// Implementation choices: the register offsets and the APB interface to the registers.
`default_nettype none
module isl_core (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [13:0] instr_i,
    input wire logic instr_valid_i,
    output logic instr_ready_o,
    input wire logic flow_change_i,
    output logic [15:0] mem_raddr_o,
    input wire logic [7:0] mem_rdata_i,
    output isl_pkg::isl_mem_wr_t mem_wr_o
);
    import isl_pkg::*;

    function automatic logic is_op(input logic [13:0] ins, input logic [13:0] mask,
                                   input logic [13:0] match);
        return (ins & mask) == match;
    endfunction

    logic run, next_run;
    logic [7:0] acc, next_acc;
    logic [2:0] status, next_status;
    logic [15:0] ptr0, next_ptr0, ptr1, next_ptr1;
    logic [1:0] stall, next_stall;
    logic [31:0] cycles, next_cycles;
    logic [31:0] prdata, next_prdata;
    isl_mem_wr_t mem_wr, next_mem_wr;

    logic take, apb_wr, apb_rd_setup, mapped;
    logic store_ind, store_idx, ptr_add, and_lit, add_lit, and_file;
    logic sel_n, ind_msb, file_ind, pre_mode, dec_mode;
    logic [15:0] ptr_cur, ptr_step, ptr_sum, eff_addr;
    logic [8:0] add_sum;
    logic [7:0] alu_res;

    assign apb_wr = psel_i && penable_i && pwrite_i;
    assign apb_rd_setup = psel_i && !penable_i;
    assign mapped = paddr_i == ADDR_CTRL || paddr_i == ADDR_ACC || paddr_i == ADDR_STATUS
        || paddr_i == ADDR_PTR0 || paddr_i == ADDR_PTR1 || paddr_i == ADDR_CYCLES;
    // No wait states: read data is registered in the setup phase
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o = prdata;
    assign mem_wr_o = mem_wr;
    assign instr_ready_o = run && (stall == 2'h0);
    assign take = instr_valid_i && instr_ready_o;

    always_comb
    begin
        store_ind = is_op(instr_i, STORE_IND_MASK, STORE_IND_MATCH);
        store_idx = is_op(instr_i, STORE_IDX_MASK, STORE_IDX_MATCH);
        ptr_add = is_op(instr_i, PTR_ADD_MASK, PTR_ADD_MATCH);
        and_lit = is_op(instr_i, LIT_MASK, AND_LIT_MATCH);
        add_lit = is_op(instr_i, LIT_MASK, ADD_LIT_MATCH);
        and_file = is_op(instr_i, LIT_MASK, AND_FILE_MATCH);
        sel_n = store_ind ? instr_i[2] : instr_i[6];
        file_ind = instr_i[6:1] == IND_PORT0_ADDR[6:1];
        if (and_file)
        begin
            sel_n = instr_i[0];
        end
        ptr_cur = sel_n ? ptr1 : ptr0;
        pre_mode = instr_i[1:0] == MODE_PRE_INC || instr_i[1:0] == MODE_PRE_DEC;
        dec_mode = instr_i[1:0] == MODE_PRE_DEC || instr_i[1:0] == MODE_POST_DEC;
        // 16-bit adders drop the carry out, so pointers wrap both ways
        ptr_step = dec_mode ? ptr_cur - 16'h0001 : ptr_cur + 16'h0001;
        ptr_sum = ptr_cur + {{10{instr_i[5]}}, instr_i[5:0]};
        if (store_ind)
        begin
            eff_addr = pre_mode ? ptr_step : ptr_cur;
        end
        else if (store_idx)
        begin
            eff_addr = ptr_sum;
        end
        else if (and_file && file_ind)
        begin
            eff_addr = ptr_cur;
        end
        else
        begin
            eff_addr = {9'h000, instr_i[6:0]};
        end
        ind_msb = (store_ind || store_idx || (and_file && file_ind)) && eff_addr[15];
        add_sum = {1'b0, acc} + {1'b0, instr_i[7:0]};
        if (and_lit)
        begin
            alu_res = acc & instr_i[7:0];
        end
        else if (add_lit)
        begin
            alu_res = add_sum[7:0];
        end
        else
        begin
            alu_res = acc & mem_rdata_i;
        end
    end

    assign mem_raddr_o = eff_addr;

    always_comb
    begin
        next_run = run;
        next_acc = acc;
        next_status = status;
        next_ptr0 = ptr0;
        next_ptr1 = ptr1;
        next_stall = (stall != 2'h0) ? stall - 2'h1 : 2'h0;
        next_cycles = (take || stall != 2'h0) ? cycles + 32'h0000_0001 : cycles;
        next_prdata = prdata;
        next_mem_wr = '0;
        next_mem_wr.addr = mem_wr.addr;
        next_mem_wr.data = mem_wr.data;
        if (take)
        begin
            // Second cycle of a flow change runs as a bubble
            next_stall = (flow_change_i ? FLOW_EXTRA_CYCLES : 2'h0)
                + (ind_msb ? IND_EXTRA_CYCLES : 2'h0);
            if (store_ind || store_idx)
            begin
                next_mem_wr.we = 1'b1;
                next_mem_wr.addr = eff_addr;
                next_mem_wr.data = acc;
            end
            if (store_ind)
            begin
                if (sel_n)
                begin
                    next_ptr1 = ptr_step;
                end
                else
                begin
                    next_ptr0 = ptr_step;
                end
            end
            if (ptr_add)
            begin
                if (sel_n)
                begin
                    next_ptr1 = ptr_sum;
                end
                else
                begin
                    next_ptr0 = ptr_sum;
                end
            end
            if (and_lit || add_lit || (and_file && !instr_i[7]))
            begin
                next_acc = alu_res;
            end
            if (and_file && instr_i[7])
            begin
                next_mem_wr.we = 1'b1;
                next_mem_wr.addr = eff_addr;
                next_mem_wr.data = alu_res;
            end
            if (and_lit || add_lit || and_file)
            begin
                next_status[ST_Z_BIT] = alu_res == 8'h00;
            end
            if (add_lit)
            begin
                next_status[ST_C_BIT] = add_sum[8];
                next_status[ST_DC_BIT] = ({1'b0, acc[3:0]} + {1'b0, instr_i[3:0]}) > 5'h0F;
            end
        end
        // A software write to CTRL, ACC, STATUS or a pointer overrides the core in the same cycle
        if (apb_wr)
        begin
            case (paddr_i)
                ADDR_CTRL: next_run = pwdata_i[CTRL_RUN_BIT];
                ADDR_ACC: next_acc = pwdata_i[7:0];
                ADDR_STATUS: next_status = pwdata_i[2:0];
                ADDR_PTR0: next_ptr0 = pwdata_i[15:0];
                ADDR_PTR1: next_ptr1 = pwdata_i[15:0];
                default: next_run = run;
            endcase
        end
        if (apb_rd_setup)
        begin
            case (paddr_i)
                ADDR_CTRL: next_prdata = {31'h0, run};
                ADDR_ACC: next_prdata = {24'h0, acc};
                ADDR_STATUS: next_prdata = {29'h0, status};
                ADDR_PTR0: next_prdata = {16'h0, ptr0};
                ADDR_PTR1: next_prdata = {16'h0, ptr1};
                ADDR_CYCLES: next_prdata = cycles;
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            run <= CTRL_RESET;
            acc <= ACC_RESET;
            status <= STATUS_RESET;
            ptr0 <= PTR_RESET;
            ptr1 <= PTR_RESET;
            stall <= 2'h0;
            cycles <= 32'h0000_0000;
            prdata <= 32'h0000_0000;
            mem_wr <= '0;
        end
        else
        begin
            run <= next_run;
            acc <= next_acc;
            status <= next_status;
            ptr0 <= next_ptr0;
            ptr1 <= next_ptr1;
            stall <= next_stall;
            cycles <= next_cycles;
            prdata <= next_prdata;
            mem_wr <= next_mem_wr;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_store_ind_write: assert property (take && store_ind |=> mem_wr.we
        && mem_wr.data == $past(acc) && mem_wr.addr == $past(eff_addr))
        else $error("indirect store did not write accumulator");
    a_store_idx_addr: assert property (take && store_idx |=> mem_wr.we
        && mem_wr.addr == $past(ptr_sum))
        else $error("indexed store used wrong address");
    a_store_flags_kept: assert property (take && (store_ind || store_idx || ptr_add)
        && !apb_wr |=> status == $past(status))
        else $error("store or pointer add changed flags");
    a_flow_two_cycles: assert property (take && flow_change_i && !ind_msb
        |=> !instr_ready_o ##1 (instr_ready_o || !run))
        else $error("flow change not two cycles");
    a_ind_extra_cycle: assert property (take && ind_msb && !flow_change_i
        |=> !instr_ready_o ##1 (instr_ready_o || !run))
        else $error("upper indirect access not one extra cycle");
    a_ptr_wrap_up: assert property (take && store_ind && !instr_i[2]
        && instr_i[1:0] == MODE_POST_INC && ptr0 == 16'hFFFF && !apb_wr |=> ptr0 == 16'h0000)
        else $error("pointer did not wrap");
    a_ptr_add_sum: assert property (take && ptr_add && !instr_i[6] && !apb_wr
        |=> ptr0 == $past(ptr_sum))
        else $error("pointer add wrong");
    a_and_lit_acc: assert property (take && and_lit && !apb_wr
        |=> acc == ($past(acc) & $past(instr_i[7:0]))
        && status[ST_C_BIT] == $past(status[ST_C_BIT])
        && status[ST_DC_BIT] == $past(status[ST_DC_BIT]))
        else $error("AND immediate wrong");
    a_add_lit_carry: assert property (take && add_lit && !apb_wr
        |=> acc == $past(add_sum[7:0]) && status[ST_C_BIT] == $past(add_sum[8]))
        else $error("add immediate wrong");
    a_and_file_dest: assert property (take && and_file && instr_i[7] && !apb_wr
        |=> mem_wr.we && mem_wr.data == $past(alu_res) && acc == $past(acc))
        else $error("AND to file went to wrong target");
    a_zero_flag: assert property (take && (and_lit || add_lit || and_file) && !apb_wr
        |=> status[ST_Z_BIT] == ($past(alu_res) == 8'h00))
        else $error("zero flag wrong");
endmodule
`default_nettype wire

// ==== isl_mem_model.sv ====
`default_nettype none
module isl_mem_model (
    input wire logic clk_i,
    input wire logic [15:0] raddr_i,
    output logic [7:0] rdata_o,
    input wire isl_pkg::isl_mem_wr_t wr_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import isl_pkg::*;
    logic [7:0] ram [65536];
    // Unwritten places give an address-made pattern, never a settled stale value
    initial
    begin
        for (int i = 0; i < 65536; i++)
        begin
            ram[i] = ~i[7:0];
        end
    end
    assign rdata_o = ram[raddr_i];
    always @(posedge clk_i)
    begin
        if (wr_i.we === 1'b1)
            ram[wr_i.addr] <= wr_i.data;
    end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import isl_pkg::*;
    typedef struct packed {
        logic [7:0] acc0;
        logic [2:0] st0;
        logic [13:0] op;
        logic [7:0] acc;
        logic [2:0] st;
    } isl_row_t;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ivalid = 1'b0, flow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata_o, r, c0;
    logic [13:0] instr = 14'h0;
    logic pready_o, pslverr_o, instr_ready_o, e;
    logic [15:0] raddr, ea;
    logic [7:0] rdata;
    isl_mem_wr_t mwr;
    int n_fail = 0, samples_checked = 0, cyc = 0, m;
    isl_row_t rows [8] = '{
        '{8'hF0, 3'h3, 14'h390F, 8'h00, 3'h7}, '{8'hF0, 3'h4, 14'h39FF, 8'hF0, 3'h0},
        '{8'hFF, 3'h0, 14'h3E01, 8'h00, 3'h7}, '{8'h08, 3'h7, 14'h3E08, 8'h10, 3'h2},
        '{8'h11, 3'h0, 14'h3E22, 8'h33, 3'h0}, '{8'h0F, 3'h4, 14'h0520, 8'h0C, 3'h0},
        '{8'hC3, 3'h0, 14'h05A0, 8'hC3, 3'h4}, '{8'h55, 3'h7, 14'h3101, 8'h55, 3'h7}};
    isl_core dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .instr_i(instr),
        .instr_valid_i(ivalid), .instr_ready_o(instr_ready_o), .flow_change_i(flow),
        .mem_raddr_o(raddr), .mem_rdata_i(rdata), .mem_wr_o(mwr));
    isl_mem_model mem (.clk_i(core_clk_i), .raddr_i(raddr), .rdata_o(rdata), .wr_i(mwr));
    initial forever #12.5 core_clk_i = ~core_clk_i;
    task automatic tally_and_finish();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Zero wait states today, but the loop keeps the master honest if that changes
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    // Returns only after any stall cycles are over, so counters are settled
    task automatic exec(input logic [13:0] op, input logic f);
        logic rdy;
        @(posedge core_clk_i);
        ivalid <= 1'b1;
        instr <= op;
        flow <= f;
        do
        begin
            @(negedge core_clk_i);
            rdy = instr_ready_o;
            @(posedge core_clk_i);
        end while (rdy !== 1'b1);
        ivalid <= 1'b0;
        flow <= 1'b0;
        do @(negedge core_clk_i); while (instr_ready_o !== 1'b1);
        // The store pulse is registered, so the memory takes it one edge later
        @(negedge core_clk_i);
    endtask
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (10) @(posedge core_clk_i);
        mem.ram[16'h0020] = 8'h3C;
        sys_rst_i <= 1'b0;
        rdchk(ADDR_CTRL, 32'h0);
        rdchk(ADDR_ACC, 32'h0);
        rdchk(ADDR_STATUS, 32'h0);
        rdchk(ADDR_PTR0, 32'h0);
        rdchk(ADDR_PTR1, 32'h0);
        rdchk(ADDR_CYCLES, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        foreach (rows[i])
        begin
            apb(1'b1, ADDR_ACC, {24'h0, rows[i].acc0});
            apb(1'b1, ADDR_STATUS, {29'h0, rows[i].st0});
            exec(rows[i].op, 1'b0);
            rdchk(ADDR_ACC, {24'h0, rows[i].acc});
            rdchk(ADDR_STATUS, {29'h0, rows[i].st});
        end
        chk({24'h0, mem.ram[16'h0020]}, 32'h0);
        apb(1'b1, ADDR_PTR0, 32'hFFFE);
        exec(14'h3105, 1'b0);
        rdchk(ADDR_PTR0, 32'h0003);
        apb(1'b1, ADDR_PTR1, 32'h0002);
        exec(14'h317C, 1'b0);
        rdchk(ADDR_PTR1, 32'hFFFE);
        for (m = 0; m < 4; m++)
        begin
            apb(1'b1, m[0] ? ADDR_PTR1 : ADDR_PTR0, 32'h0040);
            apb(1'b1, ADDR_ACC, 32'hA0 + m);
            exec(14'h0018 | {11'h0, m[0], m[1:0]}, 1'b0);
            ea = (m == 0) ? 16'h0041 : (m == 1) ? 16'h003F : 16'h0040;
            chk({24'h0, mem.ram[ea]}, 32'hA0 + m);
            rdchk(m[0] ? ADDR_PTR1 : ADDR_PTR0, m[0] ? 32'h3F : 32'h41);
        end
        apb(1'b1, ADDR_PTR0, 32'h0060);
        apb(1'b1, ADDR_ACC, 32'h77);
        exec(14'h3F9F, 1'b0);
        chk({24'h0, mem.ram[16'h007F]}, 32'h77);
        rdchk(ADDR_PTR0, 32'h0060);
        rdchk(ADDR_STATUS, 32'h7);
        apb(1'b0, ADDR_CYCLES, 32'h0);
        c0 = r;
        exec(14'h3E00, 1'b1);
        rdchk(ADDR_CYCLES, c0 + 32'd2);
        apb(1'b1, ADDR_PTR0, 32'h8010);
        apb(1'b0, ADDR_CYCLES, 32'h0);
        c0 = r;
        exec(14'h001A, 1'b0);
        rdchk(ADDR_CYCLES, c0 + 32'd2);
        chk({24'h0, mem.ram[16'h8010]}, 32'h77);
        apb(1'b0, ADDR_CYCLES, 32'h0);
        c0 = r;
        exec(14'h001A, 1'b1);
        rdchk(ADDR_CYCLES, c0 + 32'd3);
        apb(1'b1, ADDR_PTR0, 32'hFFFF);
        exec(14'h001A, 1'b0);
        rdchk(ADDR_PTR0, 32'h0000);
        chk({24'h0, mem.ram[16'hFFFF]}, 32'h77);
        apb(1'b0, 8'h18, 32'h0);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        rdchk(ADDR_CTRL, 32'h0);
        rdchk(ADDR_ACC, 32'h0);
        rdchk(ADDR_PTR1, 32'h0);
        chk({31'h0, instr_ready_o}, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
